// ===== rtl/lds_diag_regs.sv
// Diagnostic, thermal and spread-spectrum register bank with output gating
module lds_diag_regs
    import lds_pkg::*;
#(
    parameter int SPREAD_CYC0 = SPREAD_T0_US * CLK_MHZ,
    parameter int SPREAD_CYC1 = SPREAD_T1_US * CLK_MHZ,
    parameter int SPREAD_CYC2 = SPREAD_T2_US * CLK_MHZ,
    parameter int SPREAD_CYC3 = SPREAD_T3_US * CLK_MHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register access from the serial port
    input wire lds_req_t req,
    output logic [7:0] rdata_r,
    output logic rvalid_r,
    // Analog sense pins
    input wire lds_sense_t sense_in,
    // Duty data and PWM step enable
    input wire logic pwm_step,
    input wire logic [NUM_CH-1:0][7:0] duty_in,
    // Output drive and analog controls
    output logic [NUM_CH-1:0] led_on_r,
    output logic phase_delay_en_r,
    output logic over_temp_r,
    output logic [6:0] current_pct_r,
    output logic spread_en_r,
    output logic [5:0] spread_dev_r,
    output logic spread_dir_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    localparam int CYC_LIMIT = 1 << 20;

    if (SPREAD_CYC0 < 2 || SPREAD_CYC0 >= CYC_LIMIT) begin : g_chk0
        $error("SPREAD_CYC0 out of range");
    end
    if (SPREAD_CYC1 < 2 || SPREAD_CYC1 >= CYC_LIMIT) begin : g_chk1
        $error("SPREAD_CYC1 out of range");
    end
    if (SPREAD_CYC2 < 2 || SPREAD_CYC2 >= CYC_LIMIT) begin : g_chk2
        $error("SPREAD_CYC2 out of range");
    end
    if (SPREAD_CYC3 < 2 || SPREAD_CYC3 >= CYC_LIMIT) begin : g_chk3
        $error("SPREAD_CYC3 out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    logic soft_rst;
    logic wr_phase;
    logic wr_det;
    logic wr_temp;
    logic wr_spread;

    // Any other byte to the reset address is ignored
    assign soft_rst = req.wr && req.addr == ADDR_RESET && req.wdata == RESET_KEY;
    assign wr_phase = req.wr && req.addr == ADDR_PHASE;
    assign wr_det = req.wr && req.addr == ADDR_DET;
    assign wr_temp = req.wr && req.addr == ADDR_TEMP;
    assign wr_spread = req.wr && req.addr == ADDR_SPREAD;

    ////////////////////////////////////////////////////////////////////////////
    // Sense synchronisers

    lds_sense_t sense_s1;
    lds_sense_t sense_s2;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sense_s1 <= '0;
            sense_s2 <= '0;
        end else begin
            sense_s1 <= sense_in;
            sense_s2 <= sense_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase register

    logic [5:0] ps_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_delay_en_r <= 1'b0;
            ps_r <= '0;
        end else if (soft_rst) begin
            phase_delay_en_r <= REG_RESET_VAL[PH_PDE_BIT];
            ps_r <= REG_RESET_VAL[PH_PS_LSB +: 6];
        end else if (wr_phase) begin
            phase_delay_en_r <= req.wdata[PH_PDE_BIT];
            ps_r <= req.wdata[PH_PS_LSB +: 6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detect select and fault capture

    logic [1:0] det_r;
    logic [NUM_CH-1:0] res_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            det_r <= '0;
        end else if (soft_rst) begin
            det_r <= REG_RESET_VAL[1:0];
        end else if (wr_det) begin
            det_r <= req.wdata[1:0];
        end
    end

    // Snapshot on each enabling write; disabled codes keep the last result
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            res_r <= '0;
        end else if (soft_rst) begin
            res_r <= '0;
        end else if (wr_det && req.wdata[1:0] == DET_OPEN) begin
            res_r <= sense_s2.open_det;
        end else if (wr_det && req.wdata[1:0] == DET_SHORT) begin
            res_r <= sense_s2.short_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Thermal register

    logic [1:0] roll_r;
    logic [1:0] ts_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            roll_r <= '0;
            ts_r <= '0;
        end else if (soft_rst) begin
            roll_r <= REG_RESET_VAL[TEMP_ROLL_LSB +: 2];
            ts_r <= REG_RESET_VAL[TEMP_TS_LSB +: 2];
        end else if (wr_temp) begin
            roll_r <= req.wdata[TEMP_ROLL_LSB +: 2];
            ts_r <= req.wdata[TEMP_TS_LSB +: 2];
        end
    end

    // Flag is live status, so a stale threshold only costs one cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            over_temp_r <= 1'b0;
        end else begin
            over_temp_r <= sense_s2.temp_above[ts_r];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            current_pct_r <= FULL_PCT;
        end else begin
            current_pct_r <= over_temp_r ? ROLL_PCT[roll_r] : FULL_PCT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spread and full-on register

    logic [2:0] full_r;
    logic [1:0] rng_r;
    logic [1:0] clt_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            full_r <= '0;
            spread_en_r <= 1'b0;
            rng_r <= '0;
            clt_r <= '0;
        end else if (soft_rst) begin
            full_r <= REG_RESET_VAL[SPR_FULL_LSB +: 3];
            spread_en_r <= REG_RESET_VAL[SPR_EN_BIT];
            rng_r <= REG_RESET_VAL[SPR_RNG_LSB +: 2];
            clt_r <= REG_RESET_VAL[SPR_CLT_LSB +: 2];
        end else if (wr_spread) begin
            full_r <= req.wdata[SPR_FULL_LSB +: 3];
            spread_en_r <= req.wdata[SPR_EN_BIT];
            rng_r <= req.wdata[SPR_RNG_LSB +: 2];
            clt_r <= req.wdata[SPR_CLT_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            spread_dev_r <= '0;
        end else begin
            spread_dev_r <= spread_en_r ? SPREAD_DEV[rng_r] : 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Spread modulation: direction flips every half period

    logic [19:0] spr_cnt_r;
    logic [19:0] half_cyc;

    always_comb begin
        case (clt_r)
            2'h0: half_cyc = 20'(SPREAD_CYC0 / 2);
            2'h1: half_cyc = 20'(SPREAD_CYC1 / 2);
            2'h2: half_cyc = 20'(SPREAD_CYC2 / 2);
            default: half_cyc = 20'(SPREAD_CYC3 / 2);
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            spr_cnt_r <= '0;
            spread_dir_r <= 1'b0;
        end else if (!spread_en_r) begin
            spr_cnt_r <= '0;
            spread_dir_r <= 1'b0;
        end else if (spr_cnt_r >= half_cyc - 20'h00001) begin
            spr_cnt_r <= '0;
            spread_dir_r <= !spread_dir_r;
        end else begin
            spr_cnt_r <= spr_cnt_r + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output duty compare

    logic [7:0] pwm_cnt_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_cnt_r <= '0;
        end else if (pwm_step) begin
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [7:0] pos;
        // Shifted half a turn when the channel's phase bit is set
        assign pos = pwm_cnt_r + (ps_r[i / PHASE_SIZE] ? HALF_TURN : 8'h00);
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                led_on_r[i] <= 1'b0;
            end else if (full_r[i / GROUP_SIZE]) begin
                led_on_r[i] <= 1'b1;
            end else begin
                led_on_r[i] <= duty_in[i] >= DUTY_MIN_ON && pos < duty_in[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rd_val;

    always_comb begin
        rd_val = 8'h00;
        case (req.addr)
            ADDR_PHASE: rd_val = {phase_delay_en_r, 1'b0, ps_r};
            ADDR_DET: rd_val = {6'h00, det_r};
            ADDR_RES0: rd_val = {res_r[5], 1'b0, res_r[4:0], 1'b0};
            ADDR_RES1: rd_val = res_r[13:6];
            ADDR_RES2: rd_val = {res_r[19:15], 2'h0, res_r[14]};
            ADDR_RES3: rd_val = {res_r[26:25], 1'b0, res_r[24:20]};
            ADDR_RES4: rd_val = {5'h00, res_r[29:27]};
            ADDR_TEMP: rd_val = {roll_r, 1'b0, over_temp_r, 2'h0, ts_r};
            ADDR_SPREAD: rd_val = {full_r, spread_en_r, rng_r, clt_r};
            default: rd_val = 8'h00;
        endcase
    end

    // Reads answer one cycle after the request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req.rd;
            if (req.rd) begin
                rdata_r <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_DET_DISABLED_HOLDS: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wr_det && !req.wdata[1] && !soft_rst |=> $stable(res_r))
        else $error("disabled detect code changed results");

    AST_SHORT_CAPTURE: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wr_det && req.wdata[1:0] == DET_SHORT |=> res_r == $past(sense_s2.short_det))
        else $error("short results not captured");

    AST_OPEN_CAPTURE: assert property (
        @(posedge core_clk) disable iff (!resetn)
        wr_det && req.wdata[1:0] == DET_OPEN |=> res_r == $past(sense_s2.open_det))
        else $error("open results not captured");

    AST_SOFT_RESET: assert property (
        @(posedge core_clk) disable iff (!resetn)
        soft_rst |=> det_r == 2'h0 && res_r == '0 && full_r == 3'h0 && !spread_en_r && ts_r == 2'h0)
        else $error("reset register write left a register set");

    AST_FULL_ON_GROUP0: assert property (
        @(posedge core_clk) disable iff (!resetn)
        full_r[0] |=> led_on_r[9:0] == 10'h3ff)
        else $error("full-on group not driven on");

    AST_LOW_DUTY_OFF: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !full_r[0] && duty_in[0] < DUTY_MIN_ON |=> !led_on_r[0])
        else $error("duty below two turned output on");

    AST_OVER_TEMP_FLAG: assert property (
        @(posedge core_clk) disable iff (!resetn)
        sense_in.temp_above == 4'hf [*3] |=> over_temp_r)
        else $error("over-temperature flag missed");

    AST_FULL_CURRENT: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !over_temp_r |=> current_pct_r == FULL_PCT)
        else $error("current scaled while not over temperature");

    AST_ROLLOFF_CURRENT: assert property (
        @(posedge core_clk) disable iff (!resetn)
        over_temp_r |=> current_pct_r == ROLL_PCT[$past(roll_r)])
        else $error("roll-off percent not applied");

    AST_UNUSED_ZERO: assert property (
        @(posedge core_clk) disable iff (!resetn)
        req.rd && req.addr == ADDR_TEMP |=> rvalid_r && rdata_r[5] == 1'b0 && rdata_r[3:2] == 2'h0)
        else $error("unused temperature bits read nonzero");

    AST_SPREAD_OFF: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !spread_en_r |=> !spread_dir_r && spr_cnt_r == 20'h00000)
        else $error("spreading active while disabled");

endmodule

// ===== rtl/lds_pkg.sv
// Shared constants and carrier types for the LED diagnostic register bank
package lds_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PHASE = 8'h70;
    localparam logic [7:0] ADDR_DET = 8'h71;
    localparam logic [7:0] ADDR_RES0 = 8'h72;
    localparam logic [7:0] ADDR_RES1 = 8'h73;
    localparam logic [7:0] ADDR_RES2 = 8'h74;
    localparam logic [7:0] ADDR_RES3 = 8'h75;
    localparam logic [7:0] ADDR_RES4 = 8'h76;
    localparam logic [7:0] ADDR_TEMP = 8'h77;
    localparam logic [7:0] ADDR_SPREAD = 8'h78;
    localparam logic [7:0] ADDR_RESET = 8'h7f;

    // Field positions
    localparam int PH_PDE_BIT = 7;
    localparam int PH_PS_LSB = 0;
    localparam int TEMP_ROLL_LSB = 6;
    localparam int TEMP_FLAG_BIT = 4;
    localparam int TEMP_TS_LSB = 0;
    localparam int SPR_FULL_LSB = 5;
    localparam int SPR_EN_BIT = 4;
    localparam int SPR_RNG_LSB = 2;
    localparam int SPR_CLT_LSB = 0;

    // Reset values and keys
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] RESET_KEY = 8'h00;

    // Detect-select codes
    localparam logic [1:0] DET_SHORT = 2'h2;
    localparam logic [1:0] DET_OPEN = 2'h3;

    // Channel layout
    localparam int NUM_CH = 30;
    localparam int GROUP_SIZE = 10;
    localparam int PHASE_SIZE = 5;

    // Duty compare
    localparam logic [7:0] DUTY_MIN_ON = 8'h02;
    localparam logic [7:0] HALF_TURN = 8'h80;

    // Roll-off percent by code 00..11: 100, 75, 55, 30
    localparam logic [3:0][6:0] ROLL_PCT = {7'h1e, 7'h37, 7'h4b, 7'h64};
    localparam logic [6:0] FULL_PCT = 7'h64;
    // Spread deviation by code 00..11: 5, 15, 24, 34 percent
    localparam logic [3:0][5:0] SPREAD_DEV = {6'h22, 6'h18, 6'h0f, 6'h05};
    // Thermal points 140, 120, 100, 90 degC select comparator 0..3

    // Spread modulation periods
    localparam int CLK_MHZ = 250;
    localparam int SPREAD_T0_US = 1980;
    localparam int SPREAD_T1_US = 1200;
    localparam int SPREAD_T2_US = 820;
    localparam int SPREAD_T3_US = 660;

    // Register access request from the serial port decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lds_req_t;

    // Analog sense comparator outputs
    typedef struct packed {
        logic [NUM_CH-1:0] open_det;
        logic [NUM_CH-1:0] short_det;
        logic [3:0] temp_above;
    } lds_sense_t;

endpackage

// ===== test/lds_host.sv
// Host model issuing byte register accesses to the bank
module lds_host
    import lds_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register request
    output lds_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // One strobe per byte, held for a full cycle; idle address and data are
    // inverted so a stale value can never pass as a live request
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Thermal fields rewritten ahead of every status read
    task automatic temp_read(input logic [7:0] cfg);
        put(1'b1, ADDR_TEMP, cfg);
        put(1'b0, ADDR_TEMP, 8'h00);
    endtask
endmodule

// ===== test/tb_lds_diag_regs.sv
// Testbench for the diagnostic register bank
module tb_lds_diag_regs
    import lds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, resetn, pwm_step, rvalid_r, phase_delay_en_r, over_temp_r, spread_en_r, spread_dir_r;
    lds_req_t req;
    lds_sense_t sense_in;
    logic [NUM_CH-1:0][7:0] duty_in;
    logic [NUM_CH-1:0] led_on_r;
    logic [7:0] rdata_r;
    logic [6:0] current_pct_r;
    logic [5:0] spread_dev_r;
    int error_cnt = 0;
    int total_checks = 0;
    integer seed = 32'he220;
    logic [7:0] expq[$];
    logic [6:0] pct[4] = '{7'h64, 7'h4b, 7'h37, 7'h1e};
    logic [5:0] dev[4] = '{6'h05, 6'h0f, 6'h18, 6'h22};
    int half[4] = '{4, 3, 2, 1};

    // Short spread periods keep the sweep measurable
    lds_diag_regs #(.SPREAD_CYC0(8), .SPREAD_CYC1(6), .SPREAD_CYC2(4), .SPREAD_CYC3(2)) uut (
        .core_clk(core_clk), .resetn(resetn), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
        .sense_in(sense_in), .pwm_step(pwm_step), .duty_in(duty_in), .led_on_r(led_on_r),
        .phase_delay_en_r(phase_delay_en_r), .over_temp_r(over_temp_r), .current_pct_r(current_pct_r),
        .spread_en_r(spread_en_r), .spread_dev_r(spread_dev_r), .spread_dir_r(spread_dir_r));
    lds_host host (.core_clk(core_clk), .req(req));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        host.put(1'b0, a, 8'h00);
    endtask

    function automatic logic [39:0] pack(input logic [29:0] v);
        return {5'h00, v[29:27], v[26:25], 1'b0, v[24:20], v[19:15], 2'h0, v[14], v[13:6], v[5], 1'b0, v[4:0], 1'b0};
    endfunction

    task automatic rres(input logic [29:0] v);
        logic [39:0] p;
        p = pack(v);
        for (int j = 0; j < 5; j++) rx(ADDR_RES0 + 8'(j), p[8*j+:8]);
    endtask

    task automatic wait_flip(output int n);
        logic p;
        p = spread_dir_r;
        n = 0;
        while (spread_dir_r === p && n < 40) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    // Read answers are compared in order against the notes of the driver
    always @(negedge core_clk) begin
        if (rvalid_r === 1'b1) begin
            if (expq.size() == 0) check("rvalid_r", 1, 0);
            else check("rdata_r", rdata_r, expq.pop_front());
        end
    end

    initial begin
        #40000;
        error_cnt++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [29:0] fo, fs;
        logic [3:0] ta;
        logic [7:0] d;
        integer n;
        resetn = 1'b0;
        pwm_step = 1'b0;
        sense_in = '0;
        duty_in = '0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        check("current_pct_r", current_pct_r, 7'h64);
        for (int a = 'h70; a <= 'h7f; a++) rx(8'(a), 8'h00);
        rx(8'h10, 8'h00);
        wx_all: begin
            host.put(1'b1, ADDR_DET, 8'hff);
            rx(ADDR_DET, 8'h03);
            host.put(1'b1, ADDR_PHASE, 8'hff);
            rx(ADDR_PHASE, 8'hbf);
            check("phase_delay_en_r", phase_delay_en_r, 1);
        end
        $display("test defaults done");
        // Equal duty at mid-scale: alternate phase bits make adjacent groups complementary
        duty_in = {NUM_CH{8'h80}};
        pwm_step = 1'b1;
        for (int k = 0; k < 2; k++) begin
            host.put(1'b1, ADDR_PHASE, k[0] ? 8'h15 : 8'h00);
            repeat (3) @(negedge core_clk);
            repeat (16) begin
                @(negedge core_clk);
                for (int p = 0; p < 5; p++) check("led_on_r phase", led_on_r[5*p] ^ led_on_r[5*p+5], k[0]);
            end
        end
        host.put(1'b1, ADDR_PHASE, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : (k == 2) ? 8'hff : 8'($random(seed));
            duty_in = {NUM_CH{d}};
            repeat (3) @(negedge core_clk);
            n = 0;
            repeat (256) begin
                @(negedge core_clk);
                n += led_on_r[0];
            end
            check("on cycles", n, (d < 8'h02) ? 0 : d);
        end
        duty_in = {NUM_CH{8'h01}};
        for (int k = 0; k < 8; k++) begin
            host.put(1'b1, ADDR_SPREAD, {k[2:0], 5'h00});
            repeat (3) @(negedge core_clk);
            check("led_on_r", led_on_r, {{10{k[2]}}, {10{k[1]}}, {10{k[0]}}});
        end
        $display("test outputs done");
        for (int k = 0; k < 4; k++) begin
            host.put(1'b1, ADDR_SPREAD, {3'h0, 1'b1, k[1:0], ~k[1:0]});
            repeat (2) @(negedge core_clk);
            check("spread_en_r", spread_en_r, 1);
            check("spread_dev_r", spread_dev_r, dev[k]);
            wait_flip(n);
            wait_flip(n);
            check("half period", n, half[3-k]);
        end
        host.put(1'b1, ADDR_SPREAD, 8'h00);
        repeat (2) @(negedge core_clk);
        check("spread_en_r", spread_en_r, 0);
        check("spread_dev_r", spread_dev_r, 0);
        $display("test spread done");
        for (int k = 0; k < 16; k++) begin
            ta = (k == 5) ? 4'hf : 4'($random(seed));
            sense_in.temp_above = ta;
            repeat (2) @(negedge core_clk);
            expq.push_back({k[3:2], 1'b0, ta[k[1:0]], 2'h0, k[1:0]});
            host.temp_read({k[3:2], 4'h0, k[1:0]});
            check("over_temp_r", over_temp_r, ta[k[1:0]]);
            check("current_pct_r", current_pct_r, ta[k[1:0]] ? pct[k[3:2]] : 7'h64);
        end
        $display("test thermal done");
        // Current scale sits outside this bank; a host sets it to one before detection
        fo = 30'($random(seed));
        fs = 30'($random(seed));
        sense_in = '{open_det: fo, short_det: fs, temp_above: 4'h0};
        repeat (3) @(negedge core_clk);
        host.put(1'b1, ADDR_DET, 8'h02);
        rres(fs);
        host.put(1'b1, ADDR_DET, 8'h03);
        rres(fo);
        sense_in.open_det = ~fo;
        sense_in.short_det = ~fs;
        repeat (3) @(negedge core_clk);
        host.put(1'b1, ADDR_DET, 8'h00);
        host.put(1'b1, ADDR_DET, 8'h01);
        rres(fo);
        $display("test detect done");
        host.put(1'b1, ADDR_SPREAD, 8'hff);
        host.put(1'b1, ADDR_PHASE, 8'h81);
        host.put(1'b1, ADDR_RESET, 8'h55);
        rx(ADDR_SPREAD, 8'hff);
        host.put(1'b1, ADDR_RESET, 8'h00);
        for (int a = 'h70; a <= 'h78; a++) rx(8'(a), 8'h00);
        check("phase_delay_en_r", phase_delay_en_r, 0);
        check("led_on_r", led_on_r, 0);
        $display("test soft reset done");
        repeat (4) @(negedge core_clk);
        check("pending reads", expq.size(), 0);
        finish_test();
    end
endmodule
